// ---- verilog/ssfq_pkg.sv ----
/*
  Constants and types for the sensor sample queue: register offsets, field
  positions, reset values, queue geometry and the sample carrier.
  Assumes a single 10 MHz system clock and a host on a four-wire serial port.
*/
package ssfq_pkg;

  // register offsets
  localparam logic [6:0] ADDR_EVENT_SETUP = 7'h0b;
  localparam logic [6:0] ADDR_CONTROL_TWO = 7'h11;
  localparam logic [6:0] ADDR_CONTROL_THREE = 7'h12;
  localparam logic [6:0] ADDR_QUEUE_CONTROL = 7'h14;
  localparam logic [6:0] ADDR_QUEUE_STATE = 7'h26;
  localparam logic [6:0] ADDR_PRESS_XLOW = 7'h28;
  localparam logic [6:0] ADDR_PRESS_LOW = 7'h29;
  localparam logic [6:0] ADDR_PRESS_HIGH = 7'h2a;
  localparam logic [6:0] ADDR_TEMP_LOW = 7'h2b;
  localparam logic [6:0] ADDR_TEMP_HIGH = 7'h2c;

  // control_two fields
  localparam int CT2_QUEUE_EN_BIT = 6;
  localparam int CT2_STOP_THR_BIT = 5;
  localparam int CT2_ADDR_INC_BIT = 4;
  // control_three fields
  localparam int CT3_WTM_IRQ_BIT = 3;
  localparam int CT3_OVR_IRQ_BIT = 2;
  // queue_control fields: mode in [7:5], watermark in [4:0]
  localparam int QC_MODE_LSB = 5;
  // queue_state fields: flags in [7:6], level in [5:0]
  localparam int QS_WTM_BIT = 7;
  localparam int QS_OVR_BIT = 6;

  // reset values
  localparam logic [7:0] RST_EVENT_SETUP = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h10;
  localparam logic [7:0] RST_CONTROL_THREE = 8'h00;
  localparam logic [7:0] RST_QUEUE_CONTROL = 8'h00;

  // queue geometry
  localparam int QUEUE_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int LVL_W = 6;
  localparam int SKID_DEPTH = 4;
  localparam logic [5:0] LVL_FULL = 6'h20;

  // mode codes
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_STREAM = 3'h2;
  localparam logic [2:0] MODE_STR_STOP = 3'h3;
  localparam logic [2:0] MODE_BYP_STR = 3'h4;
  localparam logic [2:0] MODE_DYN = 3'h6;
  localparam logic [2:0] MODE_BYP_STOP = 3'h7;

  // effective behaviour after interrupt-active switching
  typedef enum logic [1:0] {
    EM_BYPASS = 2'h0,
    EM_STOP = 2'h1,
    EM_STREAM = 2'h3,
    EM_DYN = 2'h2
  } ssfq_eff_t;

  // serial port states, gray along idle -> command -> data
  typedef enum logic [1:0] {
    SP_IDLE = 2'h0,
    SP_CMD = 2'h1,
    SP_DATA = 2'h3
  } ssfq_spi_t;

  // one measurement: pressure word then temperature word
  typedef struct packed {
    logic [23:0] press;
    logic [15:0] temp;
  } ssfq_sample_t;

endpackage : ssfq_pkg

// ---- verilog/ssfq_top.sv ----
/*
  Sensor sample queue: 4-deep input skid buffer, 32-entry sample queue with
  seven modes, status flags, data-ready output and a four-wire serial slave
  (mode 3, MSB first, bit 7 of the command byte = read) for register access.
  Assumes samples arrive on sys_clk_in and serial pins are asynchronous.
*/
`timescale 1ns/100ps

module ssfq_skid #(
  parameter int WIDTH = 40,
  parameter int DEPTH = ssfq_pkg::SKID_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic ready_ff;
  wire push = in_valid_in && ready_ff;
  wire pop = out_valid_out && out_ready_in;
  wire [AW:0] nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready_out = ready_ff;
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = buf_mem[rd_ptr_ff];

  // ready is registered so the source sees an honest full
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b1;
    end else begin
      wr_ptr_ff <= push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
      rd_ptr_ff <= pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  // storage without reset
  always_ff @(posedge clk_in) begin
    if (push) begin
      buf_mem[wr_ptr_ff] <= in_data_in;
    end
  end
endmodule : ssfq_skid

module ssfq_top (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire ssfq_pkg::ssfq_sample_t sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic interrupt_active_flag_in,
  output logic data_ready_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // registers
  logic [7:0] event_setup_ff;
  logic [7:0] control_two_ff;
  logic [7:0] control_three_ff;
  logic [7:0] queue_control_ff;
  ssfq_pkg::ssfq_sample_t out_ff;
  // queue state
  logic [39:0] queue_mem [ssfq_pkg::QUEUE_DEPTH];
  logic [ssfq_pkg::PTR_W-1:0] wr_ptr_ff;
  logic [ssfq_pkg::PTR_W-1:0] rd_ptr_ff;
  logic [ssfq_pkg::LVL_W-1:0] level_ff;
  logic retain_ff;
  logic overrun_flag_ff;
  logic watermark_flag_ff;
  logic irq_ff;
  logic reload_ff;
  // serial port
  logic [2:0] cs_sync_ff;
  logic [2:0] clk_sync_ff;
  logic [1:0] sdi_sync_ff;
  ssfq_pkg::ssfq_spi_t spi_state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  logic [6:0] addr_ff;
  logic sdo_ff;
  logic sdo_oe_ff;

  // effective behaviour from enable, mode code and interrupt-active
  function automatic ssfq_pkg::ssfq_eff_t eff_mode(input logic en, input logic [2:0] code, input logic ia);
    ssfq_pkg::ssfq_eff_t m;
    m = ssfq_pkg::EM_BYPASS;
    if (!en) m = ssfq_pkg::EM_BYPASS;
    else if (code == ssfq_pkg::MODE_STOP) m = ssfq_pkg::EM_STOP;
    else if (code == ssfq_pkg::MODE_STREAM) m = ssfq_pkg::EM_STREAM;
    else if (code == ssfq_pkg::MODE_DYN) m = ssfq_pkg::EM_DYN;
    else if (code == ssfq_pkg::MODE_STR_STOP) m = ia ? ssfq_pkg::EM_STOP : ssfq_pkg::EM_STREAM;
    else if (code == ssfq_pkg::MODE_BYP_STR) m = ia ? ssfq_pkg::EM_STREAM : ssfq_pkg::EM_BYPASS;
    else if (code == ssfq_pkg::MODE_BYP_STOP) m = ia ? ssfq_pkg::EM_STOP : ssfq_pkg::EM_BYPASS;
    return m;
  endfunction : eff_mode

  // next sub-address; the output window wraps so bursts cycle entries
  function automatic logic [6:0] next_addr(input logic [6:0] a, input logic inc);
    if (!inc) return a;
    if (a == ssfq_pkg::ADDR_TEMP_HIGH) return ssfq_pkg::ADDR_PRESS_XLOW;
    return 7'(a + 7'h01);
  endfunction : next_addr

  // field decode
  wire queue_en = control_two_ff[ssfq_pkg::CT2_QUEUE_EN_BIT];
  wire stop_at_threshold = control_two_ff[ssfq_pkg::CT2_STOP_THR_BIT];
  wire addr_inc = control_two_ff[ssfq_pkg::CT2_ADDR_INC_BIT];
  wire watermark_irq_enable = control_three_ff[ssfq_pkg::CT3_WTM_IRQ_BIT];
  wire overrun_irq_enable = control_three_ff[ssfq_pkg::CT3_OVR_IRQ_BIT];
  wire [2:0] queue_mode_code = queue_control_ff[7:ssfq_pkg::QC_MODE_LSB];
  wire [4:0] watermark_level = queue_control_ff[4:0];
  wire ssfq_pkg::ssfq_eff_t em = eff_mode(queue_en, queue_mode_code, interrupt_active_flag_in);
  wire in_bypass = (em == ssfq_pkg::EM_BYPASS);

  // serial edge detection on synchronised pins; first stages feed only second stages
  wire cs_active = !cs_sync_ff[1];
  wire spc_rise = clk_sync_ff[1] && !clk_sync_ff[2];
  wire spc_fall = !clk_sync_ff[1] && clk_sync_ff[2];
  wire [7:0] rx_byte = {shift_ff, sdi_sync_ff[1]};
  wire byte_done = cs_active && spc_rise && (bit_cnt_ff == 3'h7);
  wire cmd_done = byte_done && (spi_state_ff == ssfq_pkg::SP_CMD);
  wire data_done = byte_done && (spi_state_ff == ssfq_pkg::SP_DATA);
  wire reg_wr = data_done && !rw_ff;
  wire entry_read = data_done && rw_ff && (addr_ff == ssfq_pkg::ADDR_TEMP_HIGH);

  // queue control terms
  wire [ssfq_pkg::LVL_W-1:0] cap = stop_at_threshold ? 6'({1'b0, watermark_level} + 6'h01) :
                                   ssfq_pkg::LVL_FULL;
  wire full = (level_ff >= cap);
  wire pop = entry_read && !in_bypass && (level_ff != '0);
  wire keep_last = pop && (em == ssfq_pkg::EM_STREAM) && (level_ff == 6'h01);
  wire ssfq_pkg::ssfq_sample_t skid_data;
  wire skid_valid;
  wire skid_take_ok = !pop; // a pop cycle stalls the input path
  wire take = skid_valid && skid_take_ok;
  wire store = take && !in_bypass && !(em == ssfq_pkg::EM_STOP && full);
  wire overwrite = store && full;
  // only plain stream counts the retained entry; other modes count new samples alone
  wire [ssfq_pkg::LVL_W-1:0] bump = (retain_ff && em == ssfq_pkg::EM_STREAM) ? 6'h02 : 6'h01;
  wire [ssfq_pkg::LVL_W-1:0] nxt_level = in_bypass ? '0 :
                                         (store && !overwrite) ? 6'(level_ff + bump) :
                                         pop ? 6'(level_ff - 6'h01) : level_ff;

  ssfq_skid #(.WIDTH(40), .DEPTH(ssfq_pkg::SKID_DEPTH)) u_skid (
    .clk_in(sys_clk_in),
    .rst_in(sys_rst_in),
    .in_data_in(sample_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .out_data_out(skid_data),
    .out_valid_out(skid_valid),
    .out_ready_in(skid_take_ok)
  );

  // queue pointers, level and flags; bypass empties everything
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff <= '0;
      retain_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      watermark_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
      reload_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      reload_ff <= pop;
      if (in_bypass) begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
        retain_ff <= 1'b0;
        overrun_flag_ff <= 1'b0;
      end else begin
        if (store) wr_ptr_ff <= 5'(wr_ptr_ff + 5'h01);
        // a retained entry is dropped once the mode is no longer plain stream
        if (overwrite || (pop && !keep_last) || (retain_ff && em != ssfq_pkg::EM_STREAM)) begin
          rd_ptr_ff <= 5'(rd_ptr_ff + 5'h01);
        end
        if (keep_last) retain_ff <= 1'b1;
        else if (store || em != ssfq_pkg::EM_STREAM) retain_ff <= 1'b0;
        // set wins over the clear by a read
        if (overwrite) overrun_flag_ff <= 1'b1;
        else if (pop) overrun_flag_ff <= 1'b0;
      end
      watermark_flag_ff <= (watermark_level != 5'h00) && (nxt_level >= {1'b0, watermark_level});
      irq_ff <= (watermark_flag_ff && watermark_irq_enable) || (overrun_flag_ff && overrun_irq_enable);
    end
  end

  // entry storage, no reset needed
  always_ff @(posedge sys_clk_in) begin
    if (store) queue_mem[wr_ptr_ff] <= skid_data;
  end

  // output window: direct in bypass, even mid-transfer; else oldest entry, held mid-transfer except a reload after each pop so entry bytes match
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_ff <= '0;
    end else if (in_bypass) begin
      if (take) out_ff <= skid_data;
    end else if (!cs_active || reload_ff) begin
      out_ff <= queue_mem[rd_ptr_ff];
    end
  end

  // register read mux
  logic [7:0] rd_byte;
  always_comb begin
    if (addr_ff == ssfq_pkg::ADDR_EVENT_SETUP) rd_byte = event_setup_ff;
    else if (addr_ff == ssfq_pkg::ADDR_CONTROL_TWO) rd_byte = control_two_ff;
    else if (addr_ff == ssfq_pkg::ADDR_CONTROL_THREE) rd_byte = control_three_ff;
    else if (addr_ff == ssfq_pkg::ADDR_QUEUE_CONTROL) rd_byte = queue_control_ff;
    else if (addr_ff == ssfq_pkg::ADDR_QUEUE_STATE) rd_byte = {watermark_flag_ff, overrun_flag_ff, level_ff};
    else if (addr_ff == ssfq_pkg::ADDR_PRESS_XLOW) rd_byte = out_ff.press[7:0];
    else if (addr_ff == ssfq_pkg::ADDR_PRESS_LOW) rd_byte = out_ff.press[15:8];
    else if (addr_ff == ssfq_pkg::ADDR_PRESS_HIGH) rd_byte = out_ff.press[23:16];
    else if (addr_ff == ssfq_pkg::ADDR_TEMP_LOW) rd_byte = out_ff.temp[7:0];
    else if (addr_ff == ssfq_pkg::ADDR_TEMP_HIGH) rd_byte = out_ff.temp[15:8];
    else rd_byte = 8'h00;
  end

  // writable registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_setup_ff <= ssfq_pkg::RST_EVENT_SETUP;
      control_two_ff <= ssfq_pkg::RST_CONTROL_TWO;
      control_three_ff <= ssfq_pkg::RST_CONTROL_THREE;
      queue_control_ff <= ssfq_pkg::RST_QUEUE_CONTROL;
    end else if (reg_wr) begin
      if (addr_ff == ssfq_pkg::ADDR_EVENT_SETUP) event_setup_ff <= rx_byte;
      else if (addr_ff == ssfq_pkg::ADDR_CONTROL_TWO) control_two_ff <= rx_byte;
      else if (addr_ff == ssfq_pkg::ADDR_CONTROL_THREE) control_three_ff <= rx_byte;
      else if (addr_ff == ssfq_pkg::ADDR_QUEUE_CONTROL) queue_control_ff <= rx_byte;
    end
  end

  // pin synchronisers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cs_sync_ff <= 3'h7;
      clk_sync_ff <= 3'h7;
      sdi_sync_ff <= 2'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], spi_cs_n_in};
      clk_sync_ff <= {clk_sync_ff[1:0], spi_clk_in};
      sdi_sync_ff <= {sdi_sync_ff[0], spi_sdi_in};
    end
  end

  // serial slave: sample on rising, shift out on falling
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spi_state_ff <= ssfq_pkg::SP_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      tx_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 7'h00;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else if (!cs_active) begin
      spi_state_ff <= ssfq_pkg::SP_IDLE;
      bit_cnt_ff <= 3'h0;
      sdo_oe_ff <= 1'b0;
    end else begin
      case (spi_state_ff)
        ssfq_pkg::SP_IDLE: begin
          spi_state_ff <= ssfq_pkg::SP_CMD;
        end
        ssfq_pkg::SP_CMD: begin
          if (cmd_done) begin
            rw_ff <= rx_byte[7];
            addr_ff <= rx_byte[6:0];
            spi_state_ff <= ssfq_pkg::SP_DATA;
          end
        end
        default: begin
          if (data_done) addr_ff <= next_addr(addr_ff, addr_inc);
        end
      endcase
      if (spc_rise) begin
        shift_ff <= rx_byte[6:0];
        bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
      end
      sdo_oe_ff <= (spi_state_ff == ssfq_pkg::SP_DATA) && rw_ff;
      if (spc_fall && spi_state_ff == ssfq_pkg::SP_DATA && rw_ff) begin
        if (bit_cnt_ff == 3'h0) begin
          sdo_ff <= rd_byte[7];
          tx_ff <= {rd_byte[6:0], 1'b0};
        end else begin
          sdo_ff <= tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign spi_sdo_out = sdo_ff;
  assign spi_sdo_oe_out = sdo_oe_ff;
  assign data_ready_irq_out = irq_ff;

  // checks
  sequence s_entry_pop;
    pop && !keep_last;
  endsequence
  sequence s_retained_empty;
    retain_ff && (level_ff == 6'h00);
  endsequence
  sequence s_drained_then_sample;
    s_retained_empty ##0 (store && em == ssfq_pkg::EM_STREAM);
  endsequence

  a_level_bound: assert property (level_ff <= ssfq_pkg::LVL_FULL) else $error("level above full");
  a_wtm_zero_low: assert property ((watermark_level == 5'h00) ##1 (watermark_level == 5'h00)
    |-> !watermark_flag_ff) else $error("watermark flag with zero watermark");
  a_wtm_set: assert property ((watermark_level != 5'h00) && $stable(watermark_level)
    && (nxt_level >= {1'b0, watermark_level}) |=> watermark_flag_ff) else $error("watermark flag missing");
  a_wtm_low_clear: assert property (nxt_level < {1'b0, watermark_level} |=> !watermark_flag_ff)
    else $error("watermark flag above level");
  a_bypass_empty: assert property (in_bypass |=> level_ff == '0 && !overrun_flag_ff)
    else $error("bypass not empty");
  a_bypass_window: assert property (in_bypass && take |=> out_ff == $past(skid_data))
    else $error("bypass window not updated");
  a_ovr_set: assert property (overwrite |=> overrun_flag_ff && $stable(level_ff))
    else $error("overwrite without overrun");
  a_stop_full: assert property (em == ssfq_pkg::EM_STOP && full && !pop |=> level_ff == $past(level_ff))
    else $error("stop mode kept storing");
  a_pop_dec: assert property (s_entry_pop |=> level_ff == 6'($past(level_ff) - 6'h01))
    else $error("pop did not decrement");
  a_retain_set: assert property (keep_last |=> retain_ff && level_ff == 6'h00)
    else $error("stream drain did not retain");
  a_stream_two: assert property (s_drained_then_sample |=> level_ff == 6'h02)
    else $error("stream retained step not 2");
  a_dyn_count: assert property (em == ssfq_pkg::EM_DYN && store && !overwrite
    |=> level_ff == 6'($past(level_ff) + 6'h01)) else $error("dynamic level not counting new samples");
  a_addr_wrap: assert property (data_done && addr_inc && addr_ff == ssfq_pkg::ADDR_TEMP_HIGH
    |=> addr_ff == ssfq_pkg::ADDR_PRESS_XLOW) else $error("burst address did not wrap");
  a_irq_route: assert property (overrun_flag_ff && overrun_irq_enable ##1 overrun_flag_ff
    |-> data_ready_irq_out) else $error("overrun not routed");
  a_depth_cap: assert property (stop_at_threshold && em == ssfq_pkg::EM_STOP && $stable(cap)
    && level_ff <= cap |=> level_ff <= cap) else $error("depth limit exceeded");
endmodule : ssfq_top

// ---- bench/ssfq_host.sv ----
/*
  Host processor model: four-wire serial master, mode 3, MSB first.
  Assumes the bench calls frame() at a falling edge of sys_clk_in; the serial
  clock moves only on those edges, with an 800 ns serial period.
*/
`timescale 1ns/100ps

module ssfq_host (
  input wire logic sys_clk_in,
  input wire logic spi_sdo_in,
  input wire logic spi_sdo_oe_in,
  output logic spi_cs_n_out,
  output logic spi_clk_out,
  output logic spi_sdi_out
);
  logic [7:0] rx_q[$];
  // undriven return line floats, so a late enable shows as unknown
  wire logic sdo_line = spi_sdo_oe_in ? spi_sdo_in : 1'bz;

  // serial clock idles high and stands still between frames
  initial begin
    spi_cs_n_out = 1'b1;
    spi_clk_out = 1'b1;
    spi_sdi_out = 1'b0;
  end

  task automatic half_bit();
    repeat (4) @(negedge sys_clk_in);
  endtask : half_bit

  // command byte then n data bytes; read bytes land in rx_q
  task automatic frame(input logic rd, input logic [6:0] addr, input int n, input logic [7:0] wdata);
    logic [7:0] tx;
    logic [7:0] rx;
    spi_cs_n_out = 1'b0;
    half_bit();
    for (int b = 0; b <= n; b++) begin
      tx = (b == 0) ? {rd, addr} : wdata;
      for (int i = 7; i >= 0; i--) begin
        spi_clk_out = 1'b0;
        spi_sdi_out = tx[i];
        half_bit();
        spi_clk_out = 1'b1;
        rx[i] = sdo_line;
        half_bit();
      end
      if (rd && b > 0) rx_q.push_back(rx);
    end
    spi_cs_n_out = 1'b1;
    spi_sdi_out = ~spi_sdi_out; // released line must not look held
    repeat (6) @(negedge sys_clk_in); // gap longer than the cs synchroniser
  endtask : frame
endmodule : ssfq_host

// ---- bench/sensor_sample_fifo_test.sv ----
/*
  Self-checking bench for the sample queue: register access over the serial
  port, mode table, watermark stop, stream retain and dynamic stream.
  Assumes ssfq_pkg, ssfq_top and ssfq_host are compiled first.
*/
`timescale 1ns/100ps

module sensor_sample_fifo_test;
  logic sys_clk_in;
  logic sys_rst_in;
  logic spi_cs_n;
  logic spi_clk;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe;
  ssfq_pkg::ssfq_sample_t sample_in;
  logic sample_valid_in;
  logic sample_ready_out;
  logic interrupt_active_flag_in;
  logic data_ready_irq_out;
  int failures;
  int compares;
  // rows: control_two, {mode, interrupt-active}, expected queue_state
  logic [19:0] rows [12] = '{20'h50000, 20'h50220, 20'h50460, 20'h50660, 20'h50720, 20'h50800,
                             20'h50960, 20'h50c60, 20'h50e00, 20'h50f20, 20'h10400, 20'h50b00};

  ssfq_top u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .spi_cs_n_in(spi_cs_n),
    .spi_clk_in(spi_clk), .spi_sdi_in(spi_sdi), .spi_sdo_out(spi_sdo), .spi_sdo_oe_out(spi_sdo_oe),
    .sample_in(sample_in), .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
    .interrupt_active_flag_in(interrupt_active_flag_in), .data_ready_irq_out(data_ready_irq_out));

  ssfq_host u_host (.sys_clk_in(sys_clk_in), .spi_sdo_in(spi_sdo), .spi_sdo_oe_in(spi_sdo_oe),
    .spi_cs_n_out(spi_cs_n), .spi_clk_out(spi_clk), .spi_sdi_out(spi_sdi));

  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame(1'b0, a, 1, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input int n);
    u_host.rx_q.delete();
    u_host.frame(1'b1, a, n, 8'h00);
  endtask : rd

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    rd(a, 1);
    check("register", u_host.rx_q[0], e);
  endtask : rchk

  task automatic st(input logic [7:0] e);
    rchk(ssfq_pkg::ADDR_QUEUE_STATE, e);
  endtask : st

  // distinct bytes per sample, pressure negative
  function automatic ssfq_pkg::ssfq_sample_t smp(input int k);
    smp = {8'h80 ^ k[7:0], k[7:0], ~k[7:0], 8'h3c, k[7:0]};
  endfunction : smp

  task automatic push(input int first, input int n);
    for (int k = first; k < first + n; k++) begin
      sample_in = smp(k);
      sample_valid_in = 1'b1;
      while (sample_ready_out !== 1'b1) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
    end
    sample_valid_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
  endtask : push

  // one burst from the first pressure byte, n entries of 5 bytes
  task automatic rd_entries(input int first, input int n);
    logic [39:0] le;
    ssfq_pkg::ssfq_sample_t s;
    rd(ssfq_pkg::ADDR_PRESS_XLOW, 5 * n);
    for (int e = 0; e < n; e++) begin
      s = smp(first + e);
      le = {s.temp, s.press};
      for (int j = 0; j < 5; j++) check("queue byte", u_host.rx_q[5 * e + j], le[8 * j +: 8]);
    end
  endtask : rd_entries

  task automatic to_mode(input logic [7:0] qc);
    wr(ssfq_pkg::ADDR_QUEUE_CONTROL, 8'h00); // bypass first clears the queue and any sample of the switch
    wr(ssfq_pkg::ADDR_QUEUE_CONTROL, qc);
  endtask : to_mode

  // watchdog at twice the expected run of about 2.5 ms
  initial begin
    #5000000;
    failures++;
    end_of_test();
  end

  initial begin
    sys_rst_in = 1'b1;
    sample_in = '0;
    sample_valid_in = 1'b0;
    interrupt_active_flag_in = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    // outputs idle after reset: input path open, return line not driven
    check("ready", {7'h00, sample_ready_out}, 8'h01);
    check("sdo enable", {7'h00, spi_sdo_oe}, 8'h00);
    check("irq", {7'h00, data_ready_irq_out}, 8'h00);
    // register reset values, unmapped and read-only places
    rchk(ssfq_pkg::ADDR_EVENT_SETUP, ssfq_pkg::RST_EVENT_SETUP);
    rchk(ssfq_pkg::ADDR_CONTROL_TWO, ssfq_pkg::RST_CONTROL_TWO);
    rchk(ssfq_pkg::ADDR_CONTROL_THREE, ssfq_pkg::RST_CONTROL_THREE);
    rchk(ssfq_pkg::ADDR_QUEUE_CONTROL, ssfq_pkg::RST_QUEUE_CONTROL);
    rchk(7'h30, 8'h00);
    wr(ssfq_pkg::ADDR_QUEUE_STATE, 8'hff);
    st(8'h00);
    wr(ssfq_pkg::ADDR_EVENT_SETUP, 8'h04);
    rchk(ssfq_pkg::ADDR_EVENT_SETUP, 8'h04);
    // increment off: a two-byte read stays on one address
    wr(ssfq_pkg::ADDR_CONTROL_TWO, 8'h40);
    rd(ssfq_pkg::ADDR_CONTROL_TWO, 2);
    check("no increment", u_host.rx_q[1], 8'h40);
    // stop at threshold: watermark 3 caps depth at 4
    wr(ssfq_pkg::ADDR_CONTROL_TWO, 8'h70);
    wr(ssfq_pkg::ADDR_CONTROL_THREE, 8'h08);
    to_mode(8'h23);
    push(10, 6);
    st(8'h84);
    check("irq", {7'h00, data_ready_irq_out}, 8'h01);
    rd_entries(10, 4);
    st(8'h00);
    check("irq", {7'h00, data_ready_irq_out}, 8'h00);
    // every mode code; interrupt-active both ways only for codes 3, 4 and 7
    wr(ssfq_pkg::ADDR_CONTROL_THREE, 8'h04);
    foreach (rows[r]) begin
      wr(ssfq_pkg::ADDR_CONTROL_TWO, rows[r][19:12]);
      interrupt_active_flag_in = rows[r][8];
      to_mode({rows[r][11:9], 5'h00});
      push(0, 34);
      st(rows[r][7:0]);
      check("irq", {7'h00, data_ready_irq_out}, {7'h00, rows[r][6]});
    end
    // bypass window holds the newest sample and a read does not pop
    rd_entries(33, 1);
    interrupt_active_flag_in = 1'b0;
    // stream: oldest two dropped, full queue in one 160-byte burst
    wr(ssfq_pkg::ADDR_CONTROL_TWO, 8'h50);
    to_mode(8'h40);
    push(0, 34);
    rd_entries(2, 32);
    st(8'h00);
    push(40, 1);
    st(8'h02);
    // dynamic stream: count and order follow only new samples
    to_mode(8'hc0);
    push(50, 2);
    rd_entries(50, 2);
    st(8'h00);
    push(52, 1);
    st(8'h01);
    rd_entries(52, 1);
    end_of_test();
  end
endmodule : sensor_sample_fifo_test
